// [verilog/drive_param_bank.sv]
/*
  Fieldbus parameter bank: bus voltage utilisation, active and latched
  warning words, most recent warning code, home-before-absolute switch
  and other-channel lock. Assumes a fieldbus front end presenting one
  request per cycle on MCLK; warning sources arrive asynchronously.
*/
// Behaviour
// RL1: Report bus voltage utilisation as signed 16-bit percent, 100 means at limit.
// RL2: Active warnings read-only, same bit layout as latched word.
// RL3: Bits 0-7: general, stage temp, motor temp, reserved, overloads, CAN.
// RL4: Bits 8-15: encoder, RS485, torque-off, undervoltage, alt bus, position, Ethernet, reserved.
// RL5: With bit 0 set, detailed general-warning cause readable separately.
// RL6: Fault clear command clears whole latched warning word.
// RL7: Latched bits 10, 11, 13 clear themselves once cause is gone.
// RL8: Bit 13 stays set while position capture runs.
// RL9: Writable switch: 1 needs homing before absolute moves; resets to 0.
// RL10: Fieldbus writes 1 to lock other channels, 0 releases; enforced.
// RL11: Lock blocks input-signal and commissioning channels, never halt.
// RL12: Latched bit sets when active bit is 1, holds until cleared.
// RL13: Writes to read-only words are ignored, contents unchanged.
`timescale 1ns/1ns
`include "drive_param_defs.svh"
module drive_param_bank
  import drive_param_pkg::*;
#(
  parameter int WARN_W = 16,
  parameter int CODE_W = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Fieldbus parameter access
  input wire param_req_type BUS_REQ,
  output param_rsp_type BUS_RSP,
  // Drive state inputs (asynchronous)
  input wire logic [WARN_W-1:0] WARN_SOURCES,
  input wire logic CAPTURE_RUNNING,
  input wire logic [15:0] VOLT_UTIL_IN,
  input wire logic [CODE_W-1:0] RECENT_CODE_IN,
  input wire logic FAULT_CLEAR_CMD,
  // Other access channels
  input wire logic INPUT_CH_REQ,
  input wire logic COMMISSION_CH_REQ,
  input wire logic HALT_IN,
  output logic INPUT_CH_GRANT,
  output logic COMMISSION_CH_GRANT,
  output logic HALT_OUT,
  // Settings
  output logic HOME_BEFORE_ABS,
  output logic OTHER_CHANNEL_LOCK
);
  logic [WARN_W-1:0] src_sync;
  logic [WARN_W-1:0] raw_warn;
  logic [WARN_W-1:0] active_ff;
  logic [WARN_W-1:0] latched_ff;
  logic [15:0] util_ff;
  logic [CODE_W-1:0] code_ff;
  logic home_ff;
  logic lock_ff;
  logic in_grant_ff;
  logic com_grant_ff;
  logic halt_ff;
  param_rsp_type rsp_ff;
  logic [WARN_W-1:0] nxt_active;
  logic [WARN_W-1:0] nxt_latched;
  logic [15:0] nxt_util;
  logic [CODE_W-1:0] nxt_code;
  logic nxt_home;
  logic nxt_lock;
  logic nxt_in_grant;
  logic nxt_com_grant;
  logic nxt_halt;
  param_rsp_type nxt_rsp;
  logic [5+CODE_W+16-1:0] misc_in;
  logic [5+CODE_W+16-1:0] misc_sync;
  logic capture_s;
  logic fault_clr_s;
  logic halt_s;
  logic in_req_s;
  logic com_req_s;
  logic [15:0] util_s;
  logic [CODE_W-1:0] code_s;

  initial begin
    if (WARN_W != 16) $error("drive_param_bank supports a 16-bit warning word only");
    if (CODE_W < 1 || CODE_W > 16) $error("drive_param_bank CODE_W must be 1..16");
  end

  // Pin synchronisers
  warn_sync #(.WIDTH(WARN_W)) u_warn_sync (
    .clk(MCLK),
    .rstn(RSTN),
    .async_in(WARN_SOURCES),
    .sync_out(src_sync)
  );

  assign misc_in = {CAPTURE_RUNNING, FAULT_CLEAR_CMD, HALT_IN, INPUT_CH_REQ,
                    COMMISSION_CH_REQ, VOLT_UTIL_IN, RECENT_CODE_IN};
  warn_sync #(.WIDTH(5+CODE_W+16)) u_misc_sync (
    .clk(MCLK),
    .rstn(RSTN),
    .async_in(misc_in),
    .sync_out(misc_sync)
  );
  assign {capture_s, fault_clr_s, halt_s, in_req_s, com_req_s, util_s, code_s} = misc_sync;

  // Live warning word with reserved bits forced low
  always_comb begin
    raw_warn = src_sync & ~`WARN_RESERVED_MASK; // RL3 RL4
    raw_warn[`WB_POS_INVALID] = src_sync[`WB_POS_INVALID] | capture_s; // RL8
  end

  // Warning state
  always_comb begin
    nxt_active = raw_warn; // RL2
    nxt_latched = latched_ff & ~(`WARN_AUTO_CLEAR_MASK & ~raw_warn); // RL7
    if (fault_clr_s) begin
      nxt_latched = '0; // RL6
    end
    nxt_latched = nxt_latched | raw_warn; // RL12
    nxt_util = util_s; // RL1
    nxt_code = raw_warn[`WB_GENERAL] ? code_s : code_ff; // RL5
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      active_ff <= `RST_WORD;
      latched_ff <= `RST_WORD;
      util_ff <= `RST_WORD;
      code_ff <= '0;
    end else begin
      active_ff <= nxt_active;
      latched_ff <= nxt_latched;
      util_ff <= nxt_util;
      code_ff <= nxt_code;
    end
  end

  // Parameter access
  always_comb begin
    nxt_home = home_ff;
    nxt_lock = lock_ff;
    nxt_rsp = '0;
    if (BUS_REQ.wr) begin
      nxt_rsp.valid = 1'b1;
      case (BUS_REQ.addr)
        `ADDR_HOME_BEFORE_ABS: nxt_home = BUS_REQ.wdata[0]; // RL9
        `ADDR_OTHER_CHANNEL_LOCK: nxt_lock = BUS_REQ.wdata[0]; // RL10
        `ADDR_ACTIVE_WARNING, `ADDR_LATCHED_WARNING, `ADDR_VOLT_UTIL,
        `ADDR_RECENT_WARNING: nxt_rsp.err = 1'b0; // RL13
        default: nxt_rsp.err = 1'b1;
      endcase
    end else if (BUS_REQ.rd) begin
      nxt_rsp.valid = 1'b1;
      case (BUS_REQ.addr)
        `ADDR_HOME_BEFORE_ABS: nxt_rsp.rdata = {15'h0000, home_ff};
        `ADDR_OTHER_CHANNEL_LOCK: nxt_rsp.rdata = {15'h0000, lock_ff};
        `ADDR_ACTIVE_WARNING: nxt_rsp.rdata = active_ff; // RL2
        `ADDR_LATCHED_WARNING: nxt_rsp.rdata = latched_ff;
        `ADDR_VOLT_UTIL: nxt_rsp.rdata = util_ff; // RL1
        `ADDR_RECENT_WARNING: nxt_rsp.rdata = 16'(code_ff); // RL5
        default: nxt_rsp.err = 1'b1;
      endcase
    end
  end

  // Channel gating
  always_comb begin
    nxt_in_grant = in_req_s & ~lock_ff; // RL10 RL11
    nxt_com_grant = com_req_s & ~lock_ff; // RL11
    nxt_halt = halt_s; // RL11
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      home_ff <= `RST_HOME_BEFORE_ABS;
      lock_ff <= `RST_LOCK;
      rsp_ff <= '0;
      in_grant_ff <= 1'b0;
      com_grant_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      home_ff <= nxt_home;
      lock_ff <= nxt_lock;
      rsp_ff <= nxt_rsp;
      in_grant_ff <= nxt_in_grant;
      com_grant_ff <= nxt_com_grant;
      halt_ff <= nxt_halt;
    end
  end

  assign BUS_RSP = rsp_ff;
  assign HOME_BEFORE_ABS = home_ff;
  assign OTHER_CHANNEL_LOCK = lock_ff;
  assign INPUT_CH_GRANT = in_grant_ff;
  assign COMMISSION_CH_GRANT = com_grant_ff;
  assign HALT_OUT = halt_ff;

  // Checks
  property p_latch_follows;
    @(posedge MCLK) disable iff (!RSTN) (active_ff != '0) |-> ((latched_ff & active_ff) == active_ff);
  endproperty
  a_latch_follows: assert property (p_latch_follows) else $error("latched misses active bit"); // RL12

  property p_fault_clear;
    @(posedge MCLK) disable iff (!RSTN) fault_clr_s |=> (latched_ff == active_ff);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault clear left stale bits"); // RL6

  property p_auto_clear;
    @(posedge MCLK) disable iff (!RSTN) !raw_warn[`WB_SAFE_TORQUE] |=> !latched_ff[`WB_SAFE_TORQUE];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("bit 10 not auto-cleared"); // RL7

  property p_capture_invalid;
    @(posedge MCLK) disable iff (!RSTN) capture_s |=> active_ff[`WB_POS_INVALID];
  endproperty
  a_capture_invalid: assert property (p_capture_invalid) else $error("bit 13 low in capture"); // RL8

  property p_reserved_low;
    @(posedge MCLK) disable iff (!RSTN) (active_ff & `WARN_RESERVED_MASK) == '0;
  endproperty
  a_reserved_low: assert property (p_reserved_low) else $error("reserved warning bit set"); // RL3

  property p_home_write;
    @(posedge MCLK) disable iff (!RSTN)
      (BUS_REQ.wr && BUS_REQ.addr == `ADDR_HOME_BEFORE_ABS) |=> (home_ff == $past(BUS_REQ.wdata[0]));
  endproperty
  a_home_write: assert property (p_home_write) else $error("home switch not written"); // RL9

  property p_lock_blocks;
    @(posedge MCLK) disable iff (!RSTN) lock_ff |=> (!in_grant_ff && !com_grant_ff);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked channel granted"); // RL10

  property p_halt_passes;
    @(posedge MCLK) disable iff (!RSTN) halt_s |=> HALT_OUT;
  endproperty
  a_halt_passes: assert property (p_halt_passes) else $error("halt blocked"); // RL11

  property p_ro_write;
    @(posedge MCLK) disable iff (!RSTN)
      (BUS_REQ.wr && BUS_REQ.addr == `ADDR_LATCHED_WARNING) |=> !BUS_RSP.err;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write faulted"); // RL13

  c_lock: cover property (@(posedge MCLK) disable iff (!RSTN) $rose(lock_ff));
  c_fault_clr: cover property (@(posedge MCLK) disable iff (!RSTN) fault_clr_s && latched_ff != '0);
  c_capture: cover property (@(posedge MCLK) disable iff (!RSTN) $fell(capture_s));
endmodule

// [verilog/drive_param_defs.svh]
/*
  Register addresses, field positions and reset values of the drive
  parameter bank. Assumes inclusion by name from the design files.
*/
`ifndef DRIVE_PARAM_DEFS_SVH
`define DRIVE_PARAM_DEFS_SVH

`define ADDR_OTHER_CHANNEL_LOCK 16'h013C
`define ADDR_HOME_BEFORE_ABS 16'h062C
`define ADDR_ACTIVE_WARNING 16'h1C16
`define ADDR_LATCHED_WARNING 16'h1C18
`define ADDR_VOLT_UTIL 16'h1E26
`define ADDR_RECENT_WARNING 16'h1C1A

`define RST_HOME_BEFORE_ABS 1'h0
`define RST_LOCK 1'h0
`define RST_WORD 16'h0000

`define WB_GENERAL 0
`define WB_PS_TEMP 1
`define WB_MOTOR_TEMP 2
`define WB_RSVD_A 3
`define WB_PS_OVERLOAD 4
`define WB_MOTOR_OVERLOAD 5
`define WB_BRAKE_RES 6
`define WB_CAN 7
`define WB_ENCODER 8
`define WB_RS485 9
`define WB_SAFE_TORQUE 10
`define WB_UNDERVOLT 11
`define WB_ALT_FIELDBUS 12
`define WB_POS_INVALID 13
`define WB_ETHERNET 14
`define WB_RSVD_B 15

`define WARN_RESERVED_MASK 16'h8008
`define WARN_AUTO_CLEAR_MASK 16'h2C00
`define UTIL_FULL_SCALE 16'sh0064

`endif

// [verilog/drive_param_pkg.sv]
/*
  Types of the drive parameter bank. Assumes the defs header alongside.
*/
package drive_param_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } param_req_type;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } param_rsp_type;

  typedef enum logic [0:0] {
    SRC_LIVE,
    SRC_CLEAR
  } unused_src_type;
endpackage

// [verilog/warn_sync.sv]
/*
  Two-stage synchroniser for a bus of asynchronous levels.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module warn_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  initial begin
    if (WIDTH < 1) $error("warn_sync WIDTH must be positive");
  end

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// [verif/fieldbus_master.sv]
/*
  Fieldbus master model: issues one parameter request per call.
  Assumes requests are taken on the rising MCLK edge.
*/
`timescale 1ns/1ns
module fieldbus_master
  import drive_param_pkg::*;
(
  // Clock
  input wire logic MCLK,
  // Requests
  output param_req_type BUS_REQ
);
  initial begin
    BUS_REQ = '0;
  end

  // Request held over one rising edge, then released with wr and rd low and address and data inverted
  task automatic access(input logic is_wr, input logic [15:0] a, input logic [15:0] d);
    @(negedge MCLK);
    BUS_REQ = '{wr: is_wr, rd: !is_wr, addr: a, wdata: d};
    @(negedge MCLK);
    BUS_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// [verif/testbench.sv]
/*
  Self-checking bench of the drive parameter bank.
  Assumes the master model and the design package and header.
*/
`timescale 1ns/1ns
`include "drive_param_defs.svh"
module testbench;
  import drive_param_pkg::*;
  logic MCLK, RSTN, CAPTURE_RUNNING, FAULT_CLEAR_CMD, INPUT_CH_REQ, COMMISSION_CH_REQ, HALT_IN;
  param_req_type BUS_REQ;
  param_rsp_type BUS_RSP;
  logic [15:0] WARN_SOURCES, VOLT_UTIL_IN, RECENT_CODE_IN;
  logic INPUT_CH_GRANT, COMMISSION_CH_GRANT, HALT_OUT, HOME_BEFORE_ABS, OTHER_CHANNEL_LOCK;
  int failures = 0;
  int n_tests = 0;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [31:0] seed = 32'h000123E0;

  drive_param_bank u_dut (.MCLK(MCLK), .RSTN(RSTN), .BUS_REQ(BUS_REQ), .BUS_RSP(BUS_RSP),
    .WARN_SOURCES(WARN_SOURCES), .CAPTURE_RUNNING(CAPTURE_RUNNING),
    .VOLT_UTIL_IN(VOLT_UTIL_IN), .RECENT_CODE_IN(RECENT_CODE_IN),
    .FAULT_CLEAR_CMD(FAULT_CLEAR_CMD), .INPUT_CH_REQ(INPUT_CH_REQ),
    .COMMISSION_CH_REQ(COMMISSION_CH_REQ), .HALT_IN(HALT_IN),
    .INPUT_CH_GRANT(INPUT_CH_GRANT), .COMMISSION_CH_GRANT(COMMISSION_CH_GRANT),
    .HALT_OUT(HALT_OUT), .HOME_BEFORE_ABS(HOME_BEFORE_ABS),
    .OTHER_CHANNEL_LOCK(OTHER_CHANNEL_LOCK));
  fieldbus_master u_master (.MCLK(MCLK), .BUS_REQ(BUS_REQ));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic err);
    exp_q.push_back({1'b1, err, x});
    u_master.access(1'b0, a, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    exp_q.push_back({1'b0, 1'b0, 16'h0000});
    u_master.access(1'b1, a, d);
  endtask

  task automatic settle;
    repeat (4) @(negedge MCLK);
  endtask

  task automatic ports(input logic [15:0] x);
    check({13'h0000, INPUT_CH_GRANT, COMMISSION_CH_GRANT, HALT_OUT}, x);
  endtask

  task automatic results;
    $display("failures %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Answer monitor
  always @(negedge MCLK) begin
    if (RSTN === 1'b1 && BUS_RSP.valid !== 1'b0) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, BUS_RSP, 1'b0);
      end else begin
        e = exp_q.pop_front();
        check({15'h0000, BUS_RSP.err}, {15'h0000, e[16]});
        if (e[17]) begin
          check(BUS_RSP.rdata, e[15:0]);
        end
      end
    end
  end

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    failures++;
    results();
  end

  initial begin
    logic [15:0] w;
    logic [15:0] code;
    RSTN = 1'b0;
    {CAPTURE_RUNNING, FAULT_CLEAR_CMD, INPUT_CH_REQ, COMMISSION_CH_REQ, HALT_IN} = 5'h00;
    {WARN_SOURCES, VOLT_UTIL_IN, RECENT_CODE_IN} = '0;
    repeat (5) @(negedge MCLK);
    RSTN = 1'b1;
    rd(`ADDR_OTHER_CHANNEL_LOCK, 16'h0000, 1'b0);
    rd(`ADDR_HOME_BEFORE_ABS, 16'h0000, 1'b0);
    rd(16'h0000, 16'h0000, 1'b1);
    wr(`ADDR_HOME_BEFORE_ABS, 16'hFFFF);
    rd(`ADDR_HOME_BEFORE_ABS, 16'h0001, 1'b0);
    check({15'h0000, HOME_BEFORE_ABS}, 16'h0001);
    wr(`ADDR_HOME_BEFORE_ABS, 16'hFFFE);
    rd(`ADDR_HOME_BEFORE_ABS, 16'h0000, 1'b0);
    {INPUT_CH_REQ, COMMISSION_CH_REQ, HALT_IN} = 3'h7;
    settle();
    ports(16'h0007);
    wr(`ADDR_OTHER_CHANNEL_LOCK, 16'h0001);
    settle();
    ports(16'h0001);
    check({15'h0000, OTHER_CHANNEL_LOCK}, 16'h0001);
    HALT_IN = 1'b0;
    settle();
    ports(16'h0000);
    wr(`ADDR_OTHER_CHANNEL_LOCK, 16'h0000);
    settle();
    ports(16'h0006);
    check({15'h0000, OTHER_CHANNEL_LOCK}, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      WARN_SOURCES = w;
      settle();
      rd(`ADDR_ACTIVE_WARNING, w & ~`WARN_RESERVED_MASK, 1'b0);
      rd(`ADDR_LATCHED_WARNING, w & ~`WARN_RESERVED_MASK, 1'b0);
      WARN_SOURCES = 16'h0000;
      settle();
      rd(`ADDR_LATCHED_WARNING, w & ~`WARN_RESERVED_MASK & ~`WARN_AUTO_CLEAR_MASK, 1'b0);
      FAULT_CLEAR_CMD = 1'b1;
      settle();
      FAULT_CLEAR_CMD = 1'b0;
      settle();
      rd(`ADDR_LATCHED_WARNING, 16'h0000, 1'b0);
    end
    CAPTURE_RUNNING = 1'b1;
    settle();
    rd(`ADDR_ACTIVE_WARNING, 16'h2000, 1'b0);
    CAPTURE_RUNNING = 1'b0;
    settle();
    rd(`ADDR_LATCHED_WARNING, 16'h0000, 1'b0);
    seed = xs(seed);
    code = seed[15:0];
    RECENT_CODE_IN = code;
    WARN_SOURCES = 16'h0001;
    settle();
    WARN_SOURCES = 16'h0000;
    RECENT_CODE_IN = ~code;
    settle();
    rd(`ADDR_RECENT_WARNING, code, 1'b0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 16'(`UTIL_FULL_SCALE) : (i == 1) ? 16'hFF9C : seed[15:0];
      VOLT_UTIL_IN = w;
      settle();
      rd(`ADDR_VOLT_UTIL, w, 1'b0);
    end
    wr(`ADDR_VOLT_UTIL, ~w);
    wr(`ADDR_LATCHED_WARNING, 16'hFFFF);
    rd(`ADDR_VOLT_UTIL, w, 1'b0);
    rd(`ADDR_LATCHED_WARNING, 16'h0001, 1'b0);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) begin
      @(negedge MCLK);
    end
    if (exp_q.size() > 0) begin
      failures++;
    end
    results();
  end
endmodule
